/* hw/adc_ctl_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, one register per word.
// Notes: Definitions only.
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFF_CLOCK_GATE 6'h00
`define OFF_MODE_PRIMARY 6'h04
`define OFF_TRIGGER_MODE 6'h08
`define OFF_ANALOG_SELECT 6'h0c
`define OFF_DIRECTION 6'h10
`define OFF_IRQ_STATUS 6'h14
`define OFF_IRQ_MASK 6'h18
`define OFF_PRIORITY 6'h1c
`define OFF_CONV_STATUS 6'h20

// ************************************************************
// Field positions
// ************************************************************
`define BIT_CLOCK_GATE 5
`define BIT_RUN 7
`define BIT_SCAN 6
`define BIT_CODE_HI 5
`define BIT_CODE_LO 1
`define BIT_COMPARATOR 0
`define BIT_TRIG_HI 7
`define BIT_TRIG_LO 6
`define BIT_ONESHOT 5
`define BIT_CONV_END 0
`define BIT_PRIO_LOW 0
`define BIT_PRIO_HIGH 1

// ************************************************************
// Reset values
// ************************************************************
`define RST_BYTE 8'h00
`define RST_PIN_DIR 8'hff
`define RST_MASK 1'h1
`define RST_PRIO 2'h3

// ************************************************************
// Conversion time
// ************************************************************
`define CONV_TIME_NS 9000
`define CLK_PERIOD_NS 10
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CODE_FAST 5'h14
`define CODE_SLOW 5'h1c
`define CODE_DEFAULT 5'h14

`endif

/* hw/adc_ctl_pkg.sv */
// Purpose: Types shared by the converter control.
// Assumes: Nothing.
// Notes: States of the conversion sequencer.
package adc_ctl_pkg;
   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_WAIT_TRIG,
      CONV_BUSY
   } conv_state_e;
endpackage

/* hw/adc_conv_timer.sv */
// Purpose: Counts one conversion time and pulses when it ends.
// Assumes: Start is held one cycle; abort wins over everything.
// Notes: Count is loaded from the caller.
`timescale 1ns/1ns
module adc_conv_timer (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic START,
   input wire logic ABORT,
   input wire logic [15:0] LOAD,
   output logic DONE,
   output logic BUSY
);
   logic [15:0] count;
   logic [15:0] next_count;
   wire last = BUSY && (count == 16'h0001);

   always_comb begin
      next_count = count;
      if (ABORT) begin
         next_count = 16'h0000;
      end else if (START) begin
         next_count = LOAD;
      end else if (BUSY) begin
         next_count = count - 16'h0001;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         count <= 16'h0000;
         DONE <= 1'b0;
      end else begin
         count <= next_count;
         DONE <= last && !ABORT;
      end
   end

   assign BUSY = (count != 16'h0000);
endmodule

/* hw/adc_ctl.sv */
// Purpose: Register control of the on-chip converter over Avalon-MM.
// Assumes: Inputs synchronous to SYS_CLK; triggers are one-cycle pulses.
// Notes: Analog path is outside; this block gates, sequences and flags.
`timescale 1ns/1ns
`include "adc_ctl_defines.svh"

// What this block does
// - Clock gate register bit 5 drives the converter clock enable.
// - Mode bit 7 permits conversion; clearing it aborts any running conversion.
// - Mode bit 0 enables the voltage comparator; zero stops it.
// - Conversion-end mask bit one blocks interrupt servicing; zero allows it.
// - Request flag reads zero until set; writing zero clears it.
// - Two-bit priority in one register; 00 highest, 11 lowest.
// - Per port 1 pin, select one routes the pin to analog input.
// - Per port 1 pin, direction one is input, output buffer off.
// - Mode bit 6 chooses scan mode (one) or select mode (zero).
// - Mode bits 5..1 hold the time code; every code gives 9 us, only 10100 is flagged exact.
// - Trigger field upper bit zero is software; 10 and 11 are hardware.
// - Trigger register bit 5: zero continuous, one one-shot conversion.
module adc_ctl (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic HW_TRIGGER,
   input wire logic [7:0] PIN_IN,
   input wire logic [7:0] PIN_OUT_DATA,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE_N,
   output logic [7:0] PIN_ANALOG,
   output logic CONV_CLK_EN,
   output logic COMPARATOR_ON,
   output logic SCAN_MODE,
   output logic CONV_ACTIVE,
   output logic CONV_DONE,
   output logic [1:0] IRQ_PRIORITY,
   output logic IRQ
);
   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0] clock_gate;
   logic [7:0] mode_primary;
   logic [7:0] trigger_mode;
   logic [7:0] analog_select;
   logic [7:0] direction;
   logic conv_end_irq_flag;
   logic conv_end_irq_mask;
   logic [1:0] priority_bits;
   logic [31:0] read_data;
   logic answered;
   logic sw_start;
   adc_ctl_pkg::conv_state_e state;
   adc_ctl_pkg::conv_state_e next_state;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // One wait cycle so read data come from a flop; a write lands with waitrequest low
   wire access = (AVS_READ || AVS_WRITE) && !answered;
   wire wr = AVS_WRITE && answered && AVS_BYTEENABLE[0];
   wire wr_gate = wr && (AVS_ADDRESS == `OFF_CLOCK_GATE);
   wire wr_mode = wr && (AVS_ADDRESS == `OFF_MODE_PRIMARY);
   wire wr_trig = wr && (AVS_ADDRESS == `OFF_TRIGGER_MODE);
   wire wr_asel = wr && (AVS_ADDRESS == `OFF_ANALOG_SELECT);
   wire wr_dir = wr && (AVS_ADDRESS == `OFF_DIRECTION);
   wire wr_stat = wr && (AVS_ADDRESS == `OFF_IRQ_STATUS);
   wire wr_mask = wr && (AVS_ADDRESS == `OFF_IRQ_MASK);
   wire wr_prio = wr && (AVS_ADDRESS == `OFF_PRIORITY);
   wire [7:0] wbyte = AVS_WRITEDATA[7:0];

   wire clk_on = clock_gate[`BIT_CLOCK_GATE];
   wire run = mode_primary[`BIT_RUN] && clk_on;
   wire oneshot = trigger_mode[`BIT_ONESHOT];
   wire hw_trig_mode = trigger_mode[`BIT_TRIG_HI];
   wire [4:0] time_code = mode_primary[`BIT_CODE_HI:`BIT_CODE_LO];
   // Only the 9 us setting is timed exactly; others map to it too
   wire code_ok = (time_code == `CODE_FAST);
   wire [15:0] conv_load = 16'(`CONV_CYCLES);
   wire timer_done;
   wire timer_busy;

   // ************************************************************
   // Conversion sequencer
   // ************************************************************
   // Hardware trigger only counts in hardware trigger mode
   wire trig_now = hw_trig_mode ? HW_TRIGGER : sw_start;
   wire start = (state != adc_ctl_pkg::CONV_BUSY) && run && trig_now
      && mode_primary[`BIT_COMPARATOR];
   wire abort = !run;

   always_comb begin
      next_state = state;
      case (state)
         adc_ctl_pkg::CONV_IDLE: begin
            if (start) begin
               next_state = adc_ctl_pkg::CONV_BUSY;
            end else if (run) begin
               next_state = adc_ctl_pkg::CONV_WAIT_TRIG;
            end
         end
         adc_ctl_pkg::CONV_WAIT_TRIG: begin
            if (abort) begin
               next_state = adc_ctl_pkg::CONV_IDLE;
            end else if (start) begin
               next_state = adc_ctl_pkg::CONV_BUSY;
            end
         end
         adc_ctl_pkg::CONV_BUSY: begin
            if (abort) begin
               next_state = adc_ctl_pkg::CONV_IDLE;
            end else if (timer_done) begin
               // Continuous restarts at once; one-shot waits for the next trigger
               next_state = oneshot ? adc_ctl_pkg::CONV_WAIT_TRIG
                  : adc_ctl_pkg::CONV_BUSY;
            end
         end
         default: begin
            next_state = adc_ctl_pkg::CONV_IDLE;
         end
      endcase
   end

   wire restart = (state == adc_ctl_pkg::CONV_BUSY) && timer_done && !oneshot && run;

   adc_conv_timer u_timer (
      .SYS_CLK(SYS_CLK),
      .RST_N(RST_N),
      .START(start || restart),
      .ABORT(abort),
      .LOAD(conv_load),
      .DONE(timer_done),
      .BUSY(timer_busy)
   );

   // ************************************************************
   // Register writes
   // ************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         clock_gate <= `RST_BYTE;
         mode_primary <= `RST_BYTE;
         trigger_mode <= `RST_BYTE;
         analog_select <= `RST_BYTE;
         direction <= `RST_PIN_DIR;
         conv_end_irq_mask <= `RST_MASK;
         priority_bits <= `RST_PRIO;
      end else begin
         if (wr_gate) clock_gate <= wbyte;
         if (wr_mode) mode_primary <= wbyte;
         if (wr_trig) trigger_mode <= wbyte;
         if (wr_asel) analog_select <= wbyte;
         if (wr_dir) direction <= wbyte;
         if (wr_mask) conv_end_irq_mask <= wbyte[`BIT_CONV_END];
         if (wr_prio) priority_bits <= wbyte[`BIT_PRIO_HIGH:`BIT_PRIO_LOW];
      end
   end

   // Software start: writing run with run already on, or turning it on
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_start <= 1'b0;
      end else begin
         sw_start <= wr_mode && wbyte[`BIT_RUN];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         conv_end_irq_flag <= 1'b0;
      end else if (timer_done) begin
         conv_end_irq_flag <= 1'b1;
      end else if (wr_stat) begin
         // Write-one-to-clear, and writing zero also clears
         conv_end_irq_flag <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= adc_ctl_pkg::CONV_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   wire [31:0] status_word = {24'h000000, 4'h0, 1'b0, code_ok, timer_busy,
      state != adc_ctl_pkg::CONV_IDLE};
   logic [31:0] read_mux;

   always_comb begin
      case (AVS_ADDRESS)
         `OFF_CLOCK_GATE: read_mux = {24'h000000, clock_gate};
         `OFF_MODE_PRIMARY: read_mux = {24'h000000, mode_primary};
         `OFF_TRIGGER_MODE: read_mux = {24'h000000, trigger_mode};
         `OFF_ANALOG_SELECT: read_mux = {24'h000000, analog_select};
         `OFF_DIRECTION: read_mux = {24'h000000, direction};
         `OFF_IRQ_STATUS: read_mux = {31'h00000000, conv_end_irq_flag};
         `OFF_IRQ_MASK: read_mux = {31'h00000000, conv_end_irq_mask};
         `OFF_PRIORITY: read_mux = {30'h00000000, priority_bits};
         `OFF_CONV_STATUS: read_mux = status_word;
         default: read_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         answered <= 1'b0;
         read_data <= 32'h00000000;
      end else begin
         answered <= access;
         if (AVS_READ && !answered) read_data <= read_mux;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !answered;
   assign AVS_READDATA = read_data;

   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1) begin : g_pin
         // Analog pins never drive, whatever the direction bit says
         assign PIN_ANALOG[n] = analog_select[n];
         assign PIN_OE_N[n] = direction[n] || analog_select[n];
         assign PIN_OUT[n] = PIN_OUT_DATA[n] && !PIN_OE_N[n];
      end
   endgenerate

   assign CONV_CLK_EN = clk_on;
   assign COMPARATOR_ON = mode_primary[`BIT_COMPARATOR] && clk_on;
   assign SCAN_MODE = mode_primary[`BIT_SCAN];
   assign CONV_ACTIVE = (state == adc_ctl_pkg::CONV_BUSY);
   assign CONV_DONE = timer_done;
   assign IRQ_PRIORITY = priority_bits;
   assign IRQ = conv_end_irq_flag && !conv_end_irq_mask;
endmodule

/* sim/adc_ctl_props.sv */
// Purpose: Port-level checks of the converter control.
// Assumes: Bound to adc_ctl; one clock domain.
// Notes: Conversion length allows a few cycles of pipeline slack.
`timescale 1ns/1ns
module adc_ctl_props (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   input wire logic [7:0] PIN_OUT_DATA,
   input wire logic [7:0] PIN_OUT,
   input wire logic [7:0] PIN_OE_N,
   input wire logic [7:0] PIN_ANALOG,
   input wire logic CONV_CLK_EN,
   input wire logic COMPARATOR_ON,
   input wire logic CONV_ACTIVE,
   input wire logic CONV_DONE,
   input wire logic [1:0] IRQ_PRIORITY,
   input wire logic IRQ
);
   localparam int MIN_CONV = 880;
   localparam int MAX_CONV = 920;
   logic [10:0] active_cnt;
   logic prev_active;
   // ****************************************
   // Conversion length counter
   // ****************************************
   // Cleared on an end pulse or after two idle cycles, so a pulse trailing the active level still sees the count
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         active_cnt <= 11'h000;
         prev_active <= 1'b0;
      end else begin
         prev_active <= CONV_ACTIVE;
         if (CONV_DONE || (!CONV_ACTIVE && !prev_active)) begin
            active_cnt <= 11'h000;
         end else if (active_cnt != 11'h7ff) begin
            active_cnt <= active_cnt + 11'h001;
         end
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("waitrequest held beyond one cycle");
   a_comp_gated: assert property (COMPARATOR_ON |-> CONV_CLK_EN)
      else $error("comparator on without clock");
   a_analog_input: assert property ((PIN_ANALOG & ~PIN_OE_N) == 8'h00)
      else $error("analog pin driven");
   a_out_gated: assert property (PIN_OUT == (PIN_OUT_DATA & ~PIN_OE_N))
      else $error("pin output not gated by drive");
   a_gate_abort: assert property ($fell(CONV_CLK_EN) |-> ##[0:2] !CONV_ACTIVE)
      else $error("conversion survives clock stop");
   a_done_pulse: assert property (CONV_DONE |=> !CONV_DONE)
      else $error("done longer than one cycle");
   a_done_active: assert property (CONV_DONE |-> $past(CONV_ACTIVE))
      else $error("done without conversion");
   a_conv_time: assert property (CONV_DONE |-> active_cnt >= MIN_CONV && active_cnt <= MAX_CONV)
      else $error("conversion length wrong");
   a_reset_state: assert property ($rose(RST_N) |-> !IRQ && PIN_OE_N == 8'hff && IRQ_PRIORITY == 2'h3)
      else $error("reset state wrong");
endmodule

/* sim/test_adc_ctl.sv */
// Purpose: Self-checking bench for the converter control.
// Assumes: Design answers each register access within twenty cycles.
// Notes: Conversion length compared against a small window.
`timescale 1ns/1ns
module test_adc_ctl;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [5:0] AVS_ADDRESS = 6'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [3:0] AVS_BYTEENABLE = 4'hf;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST, HW_TRIGGER = 1'b0;
   logic [7:0] PIN_OUT_DATA = 8'h00;
   logic [7:0] PIN_OUT, PIN_OE_N, PIN_ANALOG;
   logic CONV_CLK_EN, COMPARATOR_ON, SCAN_MODE, CONV_ACTIVE, CONV_DONE, IRQ;
   logic [1:0] IRQ_PRIORITY;
   int failures = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h0001853c;
   logic [5:0] ra [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h1c};
   logic [7:0] rm [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03};
   logic [7:0] sh [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h03};
   logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h01, 8'h03, 8'h00,
      8'h00};
   always #5 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) PIN_OUT_DATA <= PIN_OUT_DATA + 8'h5b;
   adc_ctl uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .HW_TRIGGER(HW_TRIGGER), .PIN_IN(8'h00),
      .PIN_OUT_DATA(PIN_OUT_DATA), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
      .PIN_ANALOG(PIN_ANALOG), .CONV_CLK_EN(CONV_CLK_EN), .COMPARATOR_ON(COMPARATOR_ON),
      .SCAN_MODE(SCAN_MODE), .CONV_ACTIVE(CONV_ACTIVE), .CONV_DONE(CONV_DONE),
      .IRQ_PRIORITY(IRQ_PRIORITY), .IRQ(IRQ));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic print_verdict;
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      int i;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_WRITEDATA <= {24'h000000, d};
      AVS_BYTEENABLE <= be;
      // Waitrequest looked at mid-cycle, away from the edge that changes it
      for (i = 0; i < 20; i++) begin
         @(negedge SYS_CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      if (i == 20) begin
         failures++;
         print_verdict();
      end
      @(posedge SYS_CLK);
      q = AVS_READDATA[7:0];
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 4'hf, q);
      cmp(q, e);
   endtask
   // Returns the cycle count, or the limit when no end pulse came
   task automatic wait_done(output int n);
      for (n = 0; n < 1000; n++) begin
         @(negedge SYS_CLK);
         if (CONV_DONE === 1'b1) break;
      end
   endtask
   initial begin
      repeat (100000) @(posedge SYS_CLK);
      failures++;
      print_verdict();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [7:0] q;
      int n, j;
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      for (int i = 0; i < 10; i++) rdc(6'(i * 4), rstv[i]);
      for (int k = 0; k < 30; k++) begin
         seed = xs(seed);
         j = int'(seed[10:8]) % 6;
         wr(ra[j], seed[7:0]);
         sh[j] = seed[7:0] & rm[j];
         rdc(ra[j], sh[j]);
         @(negedge SYS_CLK);
         cmp(CONV_CLK_EN, sh[0][5]);
         cmp(COMPARATOR_ON, sh[1][0] & sh[0][5]);
         cmp(SCAN_MODE, sh[1][6]);
         cmp(PIN_ANALOG, sh[3]);
         cmp(PIN_OE_N, sh[3] | sh[4]);
         cmp(IRQ_PRIORITY, sh[5][1:0]);
      end
      for (int c = 0; c < 4; c++) begin
         wr(6'h1c, 8'(c));
         wr(6'h08, 8'(c << 6));
         rdc(6'h08, 8'(c << 6));
         cmp(IRQ_PRIORITY, c);
      end
      // Refused writes leave everything as it was
      wr(6'h24, 8'h5a);
      rdc(6'h24, 8'h00);
      bus(1'b1, 6'h0c, ~sh[3], 4'he, q);
      rdc(6'h0c, sh[3]);
      // Documented bring-up order, then a one-shot software conversion
      wr(6'h04, 8'h00);
      wr(6'h00, 8'h20);
      wr(6'h14, 8'h01);
      wr(6'h18, 8'h00);
      wr(6'h08, 8'h20);
      wr(6'h04, 8'he9);
      wait_done(n);
      cmp(n >= 890 && n <= 915, 1);
      @(negedge SYS_CLK);
      cmp(IRQ, 1);
      wr(6'h18, 8'h01);
      @(negedge SYS_CLK);
      cmp(IRQ, 0);
      rdc(6'h14, 8'h01);
      wr(6'h14, 8'h00);
      rdc(6'h14, 8'h00);
      wait_done(n);
      cmp(n, 1000);
      wr(6'h08, 8'h00);
      wr(6'h04, 8'he9);
      wait_done(n);
      wait_done(n);
      cmp(n >= 890 && n <= 915, 1);
      repeat (300) @(posedge SYS_CLK);
      wr(6'h04, 8'h69);
      wait_done(n);
      cmp(n, 1000);
      rdc(6'h14, 8'h01);
      wr(6'h14, 8'h01);
      rdc(6'h14, 8'h00);
      wr(6'h08, 8'ha0);
      wr(6'h04, 8'he9);
      wait_done(n);
      cmp(n, 1000);
      @(posedge SYS_CLK);
      HW_TRIGGER <= 1'b1;
      @(posedge SYS_CLK);
      HW_TRIGGER <= 1'b0;
      wait_done(n);
      cmp(n < 1000, 1);
      print_verdict();
   end
endmodule
bind adc_ctl adc_ctl_props chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_OUT_DATA(PIN_OUT_DATA),
   .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PIN_ANALOG(PIN_ANALOG),
   .CONV_CLK_EN(CONV_CLK_EN), .COMPARATOR_ON(COMPARATOR_ON), .CONV_ACTIVE(CONV_ACTIVE),
   .CONV_DONE(CONV_DONE), .IRQ_PRIORITY(IRQ_PRIORITY), .IRQ(IRQ));
